// ==== hdl/iepr_top.sv ====
`timescale 1ns/10ps
module iepr_top (
   input wire logic clk,                 // Core clock, 10 MHz
   input wire logic rstn,                // Asynchronous reset, active low
   input wire logic [7:0] sfr_addr,      // Special-function register address
   input wire logic [7:0] sfr_wdata,     // Write data
   input wire logic sfr_wr,              // Write strobe
   input wire logic sfr_rd,              // Read strobe
   output logic [7:0] sfr_rdata,         // Registered read data
   output logic sfr_hit,                 // Registered: last read hit this block
   input wire logic [7:0] core_irq_enable, // Core enable register contents
   input wire logic [7:0] core_req,      // Core request flags, bits 0..6
   input wire logic [7:0] periph_req,    // Peripheral request flags by bit
   input wire logic in_service,          // Core is running a handler
   input wire logic [1:0] service_level, // Level of that handler
   output logic irq_valid,               // Registered: request to the core
   output logic [3:0] irq_src,           // Registered: winning source
   output logic [1:0] irq_level          // Registered: its level
);
   ////////////////////////////////////////////////////////////////////////////
   // Register file
   logic [7:0] periph_en_q;
   logic [7:0] periph_pl_q;
   logic [7:0] periph_ph_q;
   logic [7:0] core_ph_q;
   logic [7:0] core_pl_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic hit_q;
   logic hit_d;

   // Address decode
   wire sel_pen = (sfr_addr == iepr_pkg::IEPR_ADDR_PERIPH_EN);
   wire sel_ppl = (sfr_addr == iepr_pkg::IEPR_ADDR_PERIPH_PL);
   wire sel_pph = (sfr_addr == iepr_pkg::IEPR_ADDR_PERIPH_PH);
   wire sel_cph = (sfr_addr == iepr_pkg::IEPR_ADDR_CORE_PH);
   wire sel_cpl = (sfr_addr == iepr_pkg::IEPR_ADDR_CORE_PL);
   wire sel_any = sel_pen | sel_ppl | sel_pph | sel_cph | sel_cpl;

   // Reserved bits are never stored, so they cannot leak into reads
   wire [7:0] wdata_periph = sfr_wdata & iepr_pkg::IEPR_PERIPH_MASK;
   wire [7:0] wdata_core = sfr_wdata & iepr_pkg::IEPR_CORE_MASK;

   // Writes land on the strobe; all bits clear at reset
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         periph_en_q <= iepr_pkg::IEPR_RESET_VAL;
         periph_pl_q <= iepr_pkg::IEPR_RESET_VAL;
         periph_ph_q <= iepr_pkg::IEPR_RESET_VAL;
         core_ph_q <= iepr_pkg::IEPR_RESET_VAL;
         core_pl_q <= iepr_pkg::IEPR_RESET_VAL;
      end
      else if (sfr_wr)
      begin
         if (sel_pen) periph_en_q <= wdata_periph;
         if (sel_ppl) periph_pl_q <= wdata_periph;
         if (sel_pph) periph_ph_q <= wdata_periph;
         if (sel_cph) core_ph_q <= wdata_core;
         if (sel_cpl) core_pl_q <= wdata_core;
      end
   end

   // Read mux; unmapped addresses read zero; core bit 7 reads zero too
   assign rdata_d = sel_pen ? periph_en_q :
                    sel_ppl ? periph_pl_q :
                    sel_pph ? periph_ph_q :
                    sel_cph ? core_ph_q :
                    sel_cpl ? core_pl_q : 8'h00;
   assign hit_d = sfr_rd & sel_any;

   // Read data held until the next read strobe
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rdata_q <= 8'h00;
         hit_q <= 1'b0;
      end
      else if (sfr_rd)
      begin
         rdata_q <= rdata_d;
         hit_q <= hit_d;
      end
   end
   assign sfr_rdata = rdata_q;
   assign sfr_hit = hit_q;

   ////////////////////////////////////////////////////////////////////////////
   // Request gating
   wire global_en = core_irq_enable[iepr_pkg::IEPR_GLOBAL_EN_BIT];
   wire [6:0] core_gated = core_req[6:0] & core_irq_enable[6:0] & {7{global_en}};
   // Peripheral flags pass only where their enable bit is set
   wire [7:0] periph_gated = periph_req & periph_en_q & {8{global_en}};
   wire usb_g = periph_gated[iepr_pkg::IEPR_USB_BIT];
   wire keypad_g = periph_gated[iepr_pkg::IEPR_KEYPAD_BIT];
   wire adc_g = periph_gated[iepr_pkg::IEPR_ADC_BIT];
   wire spi_g = periph_gated[iepr_pkg::IEPR_SPI_BIT];
   wire two_wire_g = periph_gated[iepr_pkg::IEPR_TWO_WIRE_BIT];
   wire card_g = periph_gated[iepr_pkg::IEPR_CARD_BIT];

   // Source vector in tie order: core 0..6, card, two-wire, spi, adc, keypad, usb
   wire [12:0] src_req = {usb_g, keypad_g, adc_g, spi_g, two_wire_g, card_g, core_gated};

   // Levels: MSB from high register, LSB from low register at same position
   logic [25:0] src_level;
   always_comb
   begin
      src_level = '0;
      for (int i = 0; i < iepr_pkg::IEPR_NUM_CORE; i++)
      begin
         src_level[2*i +: 2] = {core_ph_q[i], core_pl_q[i]};
      end
      for (int j = 0; j < 5; j++)
      begin
         src_level[2*(7+j) +: 2] = {periph_ph_q[j], periph_pl_q[j]};
      end
      src_level[25:24] = {periph_ph_q[iepr_pkg::IEPR_USB_BIT],
                          periph_pl_q[iepr_pkg::IEPR_USB_BIT]};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration
   logic found;
   logic [3:0] best_idx;
   logic [1:0] best_level;

   iepr_arbiter #(
      .NUM_SRC(iepr_pkg::IEPR_NUM_SRC),
      .IDX_W(iepr_pkg::IEPR_IDX_W)
   ) u_arb (
      .req(src_req),
      .level(src_level),
      .found(found),
      .best_idx(best_idx),
      .best_level(best_level)
   );

   // A running handler is only interrupted by a strictly higher level
   wire preempt = found & (!in_service | (best_level > service_level));

   logic irq_valid_q;
   logic [3:0] irq_src_q;
   logic [1:0] irq_level_q;

   // Registered request; one cycle of latency keeps outputs glitch free
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irq_valid_q <= 1'b0;
         irq_src_q <= 4'h0;
         irq_level_q <= 2'h0;
      end
      else
      begin
         irq_valid_q <= preempt;
         irq_src_q <= preempt ? best_idx : 4'h0;
         irq_level_q <= preempt ? best_level : 2'h0;
      end
   end
   assign irq_valid = irq_valid_q;
   assign irq_src = irq_src_q;
   assign irq_level = irq_level_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   AST_USB_PASS: assert property (
      (global_en && periph_en_q[iepr_pkg::IEPR_USB_BIT] && periph_req[iepr_pkg::IEPR_USB_BIT]
      && !in_service) |=> irq_valid)
      else $error("Enabled USB request not raised");
   AST_USB_BLOCK: assert property (
      !periph_en_q[6] |=> !(irq_valid && irq_src == iepr_pkg::IEPR_IDX_USB))
      else $error("USB source won while disabled");
   AST_KEYPAD_BLOCK: assert property (
      !periph_en_q[4] |=> !(irq_valid && irq_src == 4'hb))
      else $error("Keypad source won while disabled");
   AST_ADC_BLOCK: assert property (
      !periph_en_q[3] |=> !(irq_valid && irq_src == 4'ha))
      else $error("Converter source won while disabled");
   AST_SPI_BLOCK: assert property (
      !periph_en_q[2] |=> !(irq_valid && irq_src == 4'h9))
      else $error("SPI source won while disabled");
   AST_TWO_WIRE_BLOCK: assert property (
      !periph_en_q[1] |=> !(irq_valid && irq_src == 4'h8))
      else $error("Two-wire source won while disabled");
   AST_CARD_PASS: assert property (
      (global_en && periph_en_q[0] && periph_req[0] && !in_service) |=> irq_valid)
      else $error("Enabled card request not raised");
   AST_RSVD_ZERO: assert property (
      $past(sfr_rd) && $past(sel_pen | sel_ppl | sel_pph) |-> sfr_rdata[7] == 1'b0
      && sfr_rdata[5] == 1'b0)
      else $error("Reserved peripheral bit read nonzero");
   AST_CORE_BIT7: assert property (
      $past(sfr_rd) && $past(sel_cph | sel_cpl) |-> sfr_rdata[7] == 1'b0)
      else $error("Core priority bit 7 read nonzero");
   AST_GLOBAL_OFF: assert property (
      !global_en |=> !irq_valid)
      else $error("Request raised with global enable clear");
   AST_NO_LOWER_PREEMPT: assert property (
      in_service |=> !irq_valid || irq_level > $past(service_level))
      else $error("Equal or lower level pre-empted handler");
   // A write must land whole, minus the bits that are never stored
   AST_CPH_WRITE: assert property (
      sfr_wr && sel_cph |=> core_ph_q == ($past(sfr_wdata) & iepr_pkg::IEPR_CORE_MASK))
      else $error("Core high priority write did not land");
   AST_PEN_WRITE: assert property (
      sfr_wr && sel_pen |=> periph_en_q == ($past(sfr_wdata) & iepr_pkg::IEPR_PERIPH_MASK))
      else $error("Peripheral enable write did not land");
   // Winner index is this cycle's, the register bits are those it was chosen from
   AST_CORE_LEVEL: assert property (
      irq_valid && irq_src < 4'h7 |->
      irq_level == {|(($past(core_ph_q) >> irq_src[2:0]) & 8'h01),
      |(($past(core_pl_q) >> irq_src[2:0]) & 8'h01)})
      else $error("Core source level does not match registers");

   COV_USB_WIN: cover property (irq_valid && irq_src == iepr_pkg::IEPR_IDX_USB);
   COV_PREEMPT: cover property (in_service ##1 irq_valid);
   COV_TOP_LEVEL: cover property (irq_valid && irq_level == 2'h3);
   COV_GLOBAL_BLOCK: cover property (!global_en && |(periph_req & periph_en_q));
endmodule : iepr_top

// ==== hdl/iepr_pkg.sv ====
// Operation
// - Peripheral enable bit 6 forwards USB requests when one, blocks them when zero.
// - Peripheral enable bit 4 gates keypad requests toward the arbiter.
// - Peripheral enable bit 3 gates converter requests.
// - Peripheral enable bit 2 gates SPI controller requests.
// - Peripheral enable bit 1 gates two-wire controller requests.
// - Peripheral enable bit 0 gates memory-card requests.
// - Bits 7 and 5 of peripheral enable and priority registers read zero.
// - Bit 7 of both core priority registers reads zero.
// - Core priority high register gives each core source its level MSB.
// - Core priority low register gives each core source its level LSB.
// - Peripheral priority high register gives each peripheral source its level MSB.
// - Peripheral priority low register gives each peripheral source its level LSB.
// - Global enable bit 7 of core enable must be set for any source.
package iepr_pkg;
   // Special-function register addresses
   localparam logic [7:0] IEPR_ADDR_PERIPH_EN = 8'hb1;
   localparam logic [7:0] IEPR_ADDR_PERIPH_PL = 8'hb2;
   localparam logic [7:0] IEPR_ADDR_PERIPH_PH = 8'hb3;
   localparam logic [7:0] IEPR_ADDR_CORE_PH = 8'hb7;
   localparam logic [7:0] IEPR_ADDR_CORE_PL = 8'hb8;
   // Reset value and implemented-bit masks
   localparam logic [7:0] IEPR_RESET_VAL = 8'h00;
   localparam logic [7:0] IEPR_PERIPH_MASK = 8'h5f;
   localparam logic [7:0] IEPR_CORE_MASK = 8'h7f;
   // Field positions
   localparam int IEPR_GLOBAL_EN_BIT = 7;
   localparam int IEPR_USB_BIT = 6;
   localparam int IEPR_KEYPAD_BIT = 4;
   localparam int IEPR_ADC_BIT = 3;
   localparam int IEPR_SPI_BIT = 2;
   localparam int IEPR_TWO_WIRE_BIT = 1;
   localparam int IEPR_CARD_BIT = 0;
   // Arbiter source numbering, index 0 wins ties
   localparam int IEPR_NUM_CORE = 7;
   localparam int IEPR_NUM_SRC = 13;
   localparam int IEPR_IDX_W = 4;
   localparam logic [3:0] IEPR_IDX_USB = 4'hc;
endpackage : iepr_pkg

// ==== hdl/iepr_arbiter.sv ====
`timescale 1ns/10ps
// Picks the highest level among active sources; lowest index wins a tie
module iepr_arbiter #(
   parameter int NUM_SRC = 13,
   parameter int IDX_W = 4
) (
   input wire logic [NUM_SRC-1:0] req,        // Gated requests
   input wire logic [2*NUM_SRC-1:0] level,    // Two bits per source
   output logic found,                        // Any request present
   output logic [IDX_W-1:0] best_idx,         // Winning source
   output logic [1:0] best_level              // Winning level
);
   // Scan upward; strict compare keeps the earlier source on a tie
   always_comb
   begin
      found = 1'b0;
      best_idx = '0;
      best_level = 2'h0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (req[i] && (!found || level[2*i +: 2] > best_level))
         begin
            found = 1'b1;
            best_idx = IDX_W'(i);
            best_level = level[2*i +: 2];
         end
      end
   end
endmodule : iepr_arbiter

// ==== verif/iepr_cpu_model.sv ====
`timescale 1ns/10ps
// Core-side model: single-byte register cycles, launched on the falling edge
module iepr_cpu_model (
   input wire logic clk, // Core clock
   output logic [7:0] sfr_addr, // Address
   output logic [7:0] sfr_wdata, // Write data
   output logic sfr_wr, // Write strobe
   output logic sfr_rd // Read strobe
);
   // Idle bus at time zero
   initial
   begin
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
   end
   // Strobe lasts one cycle; data inverted after release so stale bytes never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
      sfr_wdata = ~d;
   endtask : wr
   // Read data is registered, so it is settled at the falling edge after the strobe
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
   endtask : rd
endmodule : iepr_cpu_model

// ==== verif/irq_enable_priority_regs_tb.sv ====
`timescale 1ns/10ps
module irq_enable_priority_regs_tb;
   logic clk, rstn, in_service, sfr_wr, sfr_rd, sfr_hit, irq_valid;
   logic [7:0] sfr_addr, sfr_wdata, core_irq_enable, core_req, periph_req, sfr_rdata;
   logic [3:0] irq_src;
   logic [1:0] service_level, irq_level;
   int errors, check_count, cycles;
   logic [7:0] addr_tab [5] = '{8'hb1, 8'hb2, 8'hb3, 8'hb7, 8'hb8};
   logic [7:0] mask_tab [5] = '{8'h5f, 8'h5f, 8'h5f, 8'h7f, 8'h7f};
   int pos_tab [6] = '{0, 1, 2, 3, 4, 6};
   iepr_cpu_model cpu_u (.clk(clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd));
   iepr_top dut_u (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .core_irq_enable(core_irq_enable), .core_req(core_req), .periph_req(periph_req),
      .in_service(in_service), .service_level(service_level), .irq_valid(irq_valid),
      .irq_src(irq_src), .irq_level(irq_level));
   ////////////////////////////////////////////////////////////
   // Free-running clock, 100 ns period
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Hang guard: the tests need well under a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
      cpu_u.rd(a);
      chk("sfr_rdata", exp, sfr_rdata);
      chk("sfr_hit", {7'h00, hit}, {7'h00, sfr_hit});
   endtask : rdchk
   // Request outputs follow their causes by exactly one edge
   task automatic irqchk(input logic v, input logic [3:0] s, input logic [1:0] l);
      @(negedge clk);
      chk("irq", {1'b0, v, s, l}, {1'b0, irq_valid, irq_src, irq_level});
   endtask : irqchk
   task automatic t_reset_vals();
      irqchk(1'b0, 4'h0, 2'b00);
      for (int i = 0; i < 5; i++) rdchk(addr_tab[i], 8'h00, 1'b1);
      cpu_u.wr(8'hb4, 8'hff);
      rdchk(8'hb4, 8'h00, 1'b0);
      $display("test reset_vals done");
   endtask : t_reset_vals
   task automatic t_reserved();
      for (int i = 0; i < 5; i++)
      begin
         cpu_u.wr(addr_tab[i], 8'hff);
         rdchk(addr_tab[i], mask_tab[i], 1'b1);
         cpu_u.wr(addr_tab[i], 8'h00);
         rdchk(addr_tab[i], 8'h00, 1'b1);
      end
      $display("test reserved done");
   endtask : t_reserved
   // Each peripheral enable opens only its own source, and only under the global bit
   task automatic t_gating();
      core_irq_enable = 8'h80;
      for (int k = 0; k < 6; k++)
      begin
         cpu_u.wr(8'hb1, 8'h01 << pos_tab[k]);
         periph_req = 8'h01 << pos_tab[k];
         irqchk(1'b1, 4'(7 + k), 2'b00);
         core_irq_enable = 8'h00;
         irqchk(1'b0, 4'h0, 2'b00);
         core_irq_enable = 8'h80;
         cpu_u.wr(8'hb1, ~(8'h01 << pos_tab[k]));
         irqchk(1'b0, 4'h0, 2'b00);
      end
      periph_req = 8'h00;
      $display("test gating done");
   endtask : t_gating
   task automatic t_levels();
      core_irq_enable = 8'hff;
      core_req = 8'h40;
      for (int lv = 0; lv < 4; lv++)
      begin
         cpu_u.wr(8'hb7, lv[1] ? 8'h40 : 8'h00);
         cpu_u.wr(8'hb8, lv[0] ? 8'h40 : 8'h00);
         irqchk(1'b1, 4'h6, 2'(lv));
      end
      core_req = 8'h00;
      cpu_u.wr(8'hb1, 8'h40);
      periph_req = 8'h40;
      for (int lv = 0; lv < 4; lv++)
      begin
         cpu_u.wr(8'hb3, lv[1] ? 8'h40 : 8'h00);
         cpu_u.wr(8'hb2, lv[0] ? 8'h40 : 8'h00);
         irqchk(1'b1, 4'hc, 2'(lv));
      end
      $display("test levels done");
   endtask : t_levels
   // Starts with usb at level 3 against ext0 at level 0
   task automatic t_preempt();
      core_req = 8'h01;
      irqchk(1'b1, 4'hc, 2'b11);
      cpu_u.wr(8'hb3, 8'h00);
      cpu_u.wr(8'hb2, 8'h00);
      irqchk(1'b1, 4'h0, 2'b00);
      in_service = 1'b1;
      irqchk(1'b0, 4'h0, 2'b00);
      cpu_u.wr(8'hb2, 8'h40);
      irqchk(1'b1, 4'hc, 2'b01);
      service_level = 2'b01;
      irqchk(1'b0, 4'h0, 2'b00);
      $display("test preempt done");
   endtask : t_preempt
   // Reset in mid-run must clear every register again
   task automatic t_mid_reset();
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      irqchk(1'b0, 4'h0, 2'b00);
      for (int i = 0; i < 5; i++) rdchk(addr_tab[i], 8'h00, 1'b1);
      $display("test mid_reset done");
   endtask : t_mid_reset
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////
   // Reset held for twelve cycles, then the tests in turn
   initial
   begin
      rstn = 1'b0;
      in_service = 1'b0;
      service_level = 2'b00;
      core_irq_enable = 8'h00;
      core_req = 8'h00;
      periph_req = 8'h00;
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      t_reset_vals();
      t_reserved();
      t_gating();
      t_levels();
      t_preempt();
      t_mid_reset();
      close_out();
   end
endmodule : irq_enable_priority_regs_tb
